// *** ring_clock_pkg.sv ***
// constants and helpers shared by the ring network clock generator
package ring_clock_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int OSC_MHZ = 250;
	localparam int REF_KHZ = 12500;
	localparam int SYMBOL_MHZ = 25;
	localparam int BYTE_PERIOD_TICKS = (OSC_MHZ * 1000) / REF_KHZ;
	localparam int BYTE_HIGH_TICKS = BYTE_PERIOD_TICKS / 2;
	localparam int SYMBOL_PERIOD_TICKS = OSC_MHZ / SYMBOL_MHZ;
	localparam int SYMBOL_HIGH_PERCENT = 40;
	localparam int SYMBOL_HIGH_TICKS = (SYMBOL_PERIOD_TICKS * SYMBOL_HIGH_PERCENT) / 100;
	localparam int PHASE_NARROW_NS = 8;
	localparam int PHASE_WIDE_NS = 16;
	localparam int PHASE_NARROW_TICKS = (PHASE_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PHASE_WIDE_TICKS = (PHASE_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_LEAD_NS = 10;
	localparam int STROBE_LEAD_TICKS = (STROBE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_WINDOW_NS = 2;
	localparam int LOCK_WINDOW_RAW = LOCK_WINDOW_NS / CLK_PERIOD_NS;
	localparam int LOCK_WINDOW_CYCLES = (LOCK_WINDOW_RAW < 1) ? 1 : LOCK_WINDOW_RAW;
	localparam int NUM_PHASES = 5;
	localparam int PHASE_W = 5;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] CONTROL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] STEER_COUNT_OFFSET = 12'h008;
	localparam int LOOP_ENABLE_BIT = 0;
	localparam logic [31:0] CONTROL_RESET = 32'h00000001;
	localparam int STAT_LOCKED_BIT = 0;
	localparam int STAT_REF_SEL_BIT = 1;
	localparam int STAT_OSC_SEL_BIT = 2;
	localparam int STAT_SPACING_BIT = 3;
	localparam int STAT_HOLD_BIT = 4;
	localparam int STAT_PHASE_LSB = 8;
	localparam int STEER_COUNT_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic rising_edge(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	// high while the phase, shifted back by shift ticks, lies in the high half
	function automatic logic wave_high(input logic [PHASE_W-1:0] phase, input int shift);
		int p;
		p = (int'(phase) + BYTE_PERIOD_TICKS - (shift % BYTE_PERIOD_TICKS)) % BYTE_PERIOD_TICKS;
		return p < BYTE_HIGH_TICKS;
	endfunction

endpackage

// *** loop_phase_comparator.sv ***
// phase comparator between the selected reference and the loop return input
module loop_phase_comparator
	import ring_clock_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic ref_rise,
	input wire logic return_rise,
	output logic slow,
	output logic fast,
	output logic locked
);

	logic [PHASE_W-1:0] since_return;
	logic [PHASE_W-1:0] distance;
	logic [PHASE_W-1:0] late_by;
	logic seen;
	logic early;
	logic in_window;

	localparam logic [PHASE_W-1:0] PERIOD = PHASE_W'(BYTE_PERIOD_TICKS);
	localparam logic [PHASE_W-1:0] HALF = PHASE_W'(BYTE_HIGH_TICKS);
	localparam logic [PHASE_W-1:0] WINDOW = PHASE_W'(LOCK_WINDOW_CYCLES);

	// distance of the last return edge before this reference edge
	assign distance = return_rise ? '0 : since_return;
	assign seen = distance < PERIOD;
	assign early = distance <= HALF;
	assign late_by = PERIOD - distance;
	assign in_window = early ? (distance <= WINDOW) : (late_by <= WINDOW);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			since_return <= PERIOD;
		else if (return_rise)
			since_return <= PHASE_W'(1);
		else if (since_return < PERIOD)
			since_return <= since_return + PHASE_W'(1);
	end

	// one tick correction per reference edge: early return slows the chain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			slow <= 1'b0;
			fast <= 1'b0;
			locked <= 1'b0;
		end
		else
		begin
			slow <= enable && ref_rise && seen && early && (distance != '0);
			fast <= enable && ref_rise && seen && !early;
			if (ref_rise)
				locked <= seen && in_window;
		end
	end

endmodule

// *** osc_divider_chain.sv ***
// single divider chain producing every output clock from oscillator ticks
module osc_divider_chain
	import ring_clock_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic hold,
	input wire logic tick,
	input wire logic slow,
	input wire logic fast,
	input wire logic spacing_wide,
	output logic [PHASE_W-1:0] phase,
	output logic bit_clock,
	output logic strobe,
	output logic [NUM_PHASES-1:0] byte_phases,
	output logic symbol
);

	logic [PHASE_W-1:0] step;
	logic [PHASE_W:0] sum;
	logic [PHASE_W-1:0] next_phase;
	logic [NUM_PHASES-1:0] next_byte;
	int spacing;

	localparam logic [PHASE_W:0] PERIOD = (PHASE_W+1)'(BYTE_PERIOD_TICKS);

	assign step = fast ? PHASE_W'(2) : (slow ? PHASE_W'(0) : PHASE_W'(1));
	assign sum = {1'b0, phase} + {1'b0, step};
	assign next_phase = (sum >= PERIOD) ? PHASE_W'(sum - PERIOD) : sum[PHASE_W-1:0];
	assign spacing = spacing_wide ? PHASE_WIDE_TICKS : PHASE_NARROW_TICKS;

	// one shift per phase; even the widest wide shift, 16 ticks, stays inside the period
	always_comb
	begin
		next_byte = '0;
		for (int k = 0; k < NUM_PHASES; k++)
			next_byte[k] = wave_high(phase, k * spacing);
	end

	// hold restarts the chain at phase zero so all outputs realign
	always_ff @(posedge aclk)
	begin
		if (!aresetn || hold)
			phase <= '0;
		else if (tick)
			phase <= next_phase;
	end

	// all outputs re-registered from the same phase, so one cycle lag everywhere
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bit_clock <= 1'b0;
			strobe <= 1'b0;
			byte_phases <= '0;
			symbol <= 1'b0;
		end
		else
		begin
			bit_clock <= ~phase[0];
			strobe <= wave_high(phase, BYTE_PERIOD_TICKS - STROBE_LEAD_TICKS);
			byte_phases <= next_byte;
			symbol <= (int'(phase) % SYMBOL_PERIOD_TICKS) >= (SYMBOL_PERIOD_TICKS - SYMBOL_HIGH_TICKS);
		end
	end

endmodule

// *** ring_network_clock_generator.sv ***
// ring network clock generator: reference and oscillator select, loop, outputs, register slave
//
// Function
// - A low reference select uses the crystal input as loop reference, a high one the external reference.
// - A high oscillator source select runs from the internal oscillator, a low one from the outside inputs.
// - While oscillator hold is high the internal oscillator stops and its stages restart from rest.
// - A differential 125 MHz bit rate transmit clock is driven for the physical layer.
// - A differential 12.5 MHz serial load strobe changes on falling edges of the positive transmit clock.
// - The serial load strobe is phase coherent with byte phase one and leads it by about 10 ns.
// - Five 12.5 MHz byte clock phases with even high and low times are locked to the reference.
// - Byte phases are 8 ns apart with spacing select low and 16 ns apart with it high.
// - A 25 MHz symbol clock is high 40% of each period and falls on transitions of byte phase one.
// - The phase comparator steers the oscillator so the loop return input closes on the reference.
// - In lock the loop return input matches the reference frequency and lies within one 4 ns clock cycle of it.
// - The internal oscillator runs at a nominal 250 MHz, twenty times the reference.
module ring_network_clock_generator
	import ring_clock_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic reference_select,
	input wire logic crystal_input,
	input wire logic reference_input,
	input wire logic oscillator_source_select,
	input wire logic outside_oscillator_input_p,
	input wire logic outside_oscillator_input_n,
	input wire logic oscillator_hold,
	input wire logic phase_spacing_select,
	input wire logic loop_return_input,
	output logic bit_rate_transmit_clock_p,
	output logic bit_rate_transmit_clock_n,
	output logic serial_load_strobe_p,
	output logic serial_load_strobe_n,
	output logic [NUM_PHASES-1:0] byte_clock_phases,
	output logic symbol_rate_clock
);

	////////////////////////////////////////////////////////////////////////
	// reference and oscillator selection

	logic selected_ref;
	logic ref_prev;
	logic ref_rise;
	logic return_prev;
	logic return_rise;
	logic outside_level;
	logic outside_prev;
	logic outside_rise;
	logic osc_tick;

	assign selected_ref = reference_select ? reference_input : crystal_input;
	assign ref_rise = rising_edge(selected_ref, ref_prev);
	assign return_rise = rising_edge(loop_return_input, return_prev);
	assign outside_level = outside_oscillator_input_p & ~outside_oscillator_input_n;
	assign outside_rise = rising_edge(outside_level, outside_prev);

	// internal oscillator ticks every cycle; the outside one only on its rising edges,
	// so an outside source is limited to half the system clock
	assign osc_tick = !oscillator_hold && (oscillator_source_select ? 1'b1 : outside_rise);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_prev <= 1'b0;
			return_prev <= 1'b0;
			outside_prev <= 1'b0;
		end
		else
		begin
			ref_prev <= selected_ref;
			return_prev <= loop_return_input;
			outside_prev <= outside_level;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// loop and divider chain

	logic [31:0] control;
	logic steer_slow;
	logic steer_fast;
	logic loop_locked;
	logic [PHASE_W-1:0] chain_phase;
	logic chain_bit_clock;
	logic chain_strobe;
	logic [NUM_PHASES-1:0] chain_bytes;
	logic chain_symbol;

	loop_phase_comparator comparator
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(control[LOOP_ENABLE_BIT]),
		.ref_rise(ref_rise),
		.return_rise(return_rise),
		.slow(steer_slow),
		.fast(steer_fast),
		.locked(loop_locked)
	);

	osc_divider_chain chain
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.hold(oscillator_hold),
		.tick(osc_tick),
		.slow(steer_slow),
		.fast(steer_fast),
		.spacing_wide(phase_spacing_select),
		.phase(chain_phase),
		.bit_clock(chain_bit_clock),
		.strobe(chain_strobe),
		.byte_phases(chain_bytes),
		.symbol(chain_symbol)
	);

	// differential halves registered apart so each pin leaves a flop
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bit_rate_transmit_clock_p <= 1'b0;
			bit_rate_transmit_clock_n <= 1'b1;
			serial_load_strobe_p <= 1'b0;
			serial_load_strobe_n <= 1'b1;
			byte_clock_phases <= '0;
			symbol_rate_clock <= 1'b0;
		end
		else
		begin
			bit_rate_transmit_clock_p <= chain_bit_clock;
			bit_rate_transmit_clock_n <= ~chain_bit_clock;
			serial_load_strobe_p <= chain_strobe;
			serial_load_strobe_n <= ~chain_strobe;
			byte_clock_phases <= chain_bytes;
			symbol_rate_clock <= chain_symbol;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic write_go;
	logic wr_is_control;
	logic wr_is_status;
	logic wr_is_steer;
	logic wr_mapped;
	logic steer_clear;

	// registers decode on the word index; the two byte lane bits are ignored
	function automatic logic hits_word(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
		return addr[ADDR_W-1:2] == offset[ADDR_W-1:2];
	endfunction

	// commit one cycle after both halves are in, so latched address and data are settled
	assign write_go = !awready && !wready && !bvalid;
	assign wr_is_control = hits_word(aw_addr, CONTROL_OFFSET);
	assign wr_is_status = hits_word(aw_addr, STATUS_OFFSET);
	assign wr_is_steer = hits_word(aw_addr, STEER_COUNT_OFFSET);
	assign wr_mapped = wr_is_control || wr_is_status || wr_is_steer;
	assign steer_clear = write_go && wr_is_steer;

	// address and data are taken in either order; the response waits for both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_addr <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_data <= wdata;
				w_strb <= wstrb;
				wready <= 1'b0;
			end
			if (write_go)
			begin
				bvalid <= 1'b1;
				bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			control <= CONTROL_RESET;
		else if (write_go && wr_is_control && w_strb[0])
			control <= {31'h00000000, w_data[LOOP_ENABLE_BIT]};
	end

	////////////////////////////////////////////////////////////////////////
	// steering activity counter

	logic [STEER_COUNT_W-1:0] steer_count;
	logic steer_event;

	assign steer_event = steer_slow || steer_fast;

	// a correction in the clearing cycle still counts as one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			steer_count <= '0;
		else if (steer_clear)
			steer_count <= {{(STEER_COUNT_W-1){1'b0}}, steer_event};
		else if (steer_event && steer_count != '1)
			steer_count <= steer_count + STEER_COUNT_W'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	logic [31:0] status_word;
	logic [31:0] read_word;
	logic rd_is_control;
	logic rd_is_status;
	logic rd_is_steer;
	logic rd_mapped;

	assign rd_is_control = hits_word(araddr, CONTROL_OFFSET);
	assign rd_is_status = hits_word(araddr, STATUS_OFFSET);
	assign rd_is_steer = hits_word(araddr, STEER_COUNT_OFFSET);
	assign rd_mapped = rd_is_control || rd_is_status || rd_is_steer;

	// phase field is live, so two reads in a row may differ
	always_comb
	begin
		status_word = '0;
		status_word[STAT_LOCKED_BIT] = loop_locked;
		status_word[STAT_REF_SEL_BIT] = reference_select;
		status_word[STAT_OSC_SEL_BIT] = oscillator_source_select;
		status_word[STAT_SPACING_BIT] = phase_spacing_select;
		status_word[STAT_HOLD_BIT] = oscillator_hold;
		status_word[STAT_PHASE_LSB +: PHASE_W] = chain_phase;
	end

	assign read_word = rd_is_control ? control :
		rd_is_status ? status_word :
		rd_is_steer ? {{(32-STEER_COUNT_W){1'b0}}, steer_count} : 32'h00000000;

	// data latched at the address handshake, so it holds while rvalid stands
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= read_word;
			rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule

// *** ring_network_clock_generator_checker.sv ***
// concurrent checks on the clock generator outputs and register bus handshakes
module ring_network_clock_generator_checker
	import ring_clock_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic oscillator_hold,
	input wire logic phase_spacing_select,
	input wire logic bit_rate_transmit_clock_p,
	input wire logic bit_rate_transmit_clock_n,
	input wire logic serial_load_strobe_p,
	input wire logic serial_load_strobe_n,
	input wire logic [NUM_PHASES-1:0] byte_clock_phases,
	input wire logic symbol_rate_clock
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// outputs lag the phase by two flops, so edge relations wait out reset
	logic [2:0] since_rst;
	logic settled;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			since_rst <= 3'h0;
		else if (since_rst != 3'h7)
			since_rst <= since_rst + 3'h1;
	end
	assign settled = (since_rst == 3'h7) && !oscillator_hold;

	////////////////////////////////////////////////////////////////////////
	a_tx_clock_pair: assert property (bit_rate_transmit_clock_p != bit_rate_transmit_clock_n)
		else $error("transmit clock pair not complementary");
	a_strobe_pair: assert property (serial_load_strobe_p != serial_load_strobe_n)
		else $error("load strobe pair not complementary");
	a_strobe_on_fall: assert property (settled && $changed(serial_load_strobe_p)
		&& $changed(bit_rate_transmit_clock_p) |-> !bit_rate_transmit_clock_p)
		else $error("load strobe moved off a transmit clock fall");
	a_strobe_lead: assert property (settled && (serial_load_strobe_p != byte_clock_phases[0])
		|-> symbol_rate_clock)
		else $error("load strobe lead over byte phase one is wrong");
	a_symbol_fall: assert property (settled && $fell(symbol_rate_clock)
		|-> $changed(byte_clock_phases[0]))
		else $error("symbol clock fell away from a byte phase one edge");
	a_hold_rest: assert property ((oscillator_hold && $stable(phase_spacing_select)) [*5]
		|-> byte_clock_phases == (phase_spacing_select ? 5'h19 : 5'h01) && serial_load_strobe_p
		&& bit_rate_transmit_clock_p && !symbol_rate_clock)
		else $error("outputs not parked at phase zero during hold");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response missing");
	a_one_write: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while a response is pending");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data missing");
	a_read_stall: assert property (rvalid |-> !arready)
		else $error("read accepted while data is pending");

	c_hold: cover property (oscillator_hold [*5]);
	c_fall: cover property (settled && $fell(symbol_rate_clock));
	c_write: cover property (awvalid && awready && wvalid && wready);
endmodule

bind ring_network_clock_generator ring_network_clock_generator_checker u_checker (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .oscillator_hold(oscillator_hold),
	.phase_spacing_select(phase_spacing_select), .bit_rate_transmit_clock_p(bit_rate_transmit_clock_p),
	.bit_rate_transmit_clock_n(bit_rate_transmit_clock_n), .serial_load_strobe_p(serial_load_strobe_p),
	.serial_load_strobe_n(serial_load_strobe_n), .byte_clock_phases(byte_clock_phases),
	.symbol_rate_clock(symbol_rate_clock));

// *** ring_clock_partner.sv ***
// far side model: reference sources, outside oscillator and loop return wiring
module ring_clock_partner #(
	parameter int REF_OFFSET = 7
)
(
	input wire logic aclk,
	input wire logic outside_run,
	input wire logic [4:0] byte_clock_phases,
	output logic crystal_input,
	output logic reference_input,
	output logic outside_oscillator_input_p,
	output logic outside_oscillator_input_n,
	output logic loop_return_input
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt = 5'h00;
	logic osc = 1'b0;

	// both references are twenty oscillator ticks long, the external one offset in phase
	always @(posedge aclk)
	begin
		cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
		if (outside_run)
			osc <= ~osc;
	end
	assign crystal_input = cnt < 5'h0A;
	assign reference_input = ((int'(cnt) + REF_OFFSET) % 20) < 10;
	assign outside_oscillator_input_p = osc;
	assign outside_oscillator_input_n = ~osc;
	// loop closed from byte phase one, as a board would wire it
	assign loop_return_input = byte_clock_phases[0];
endmodule

// *** test_ring_network_clock_generator.sv ***
// self-checking bench for the ring network clock generator
module test_ring_network_clock_generator
	import ring_clock_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, outside_run = 1'b0;
	logic [ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic reference_select = 1'b0, oscillator_source_select = 1'b1, oscillator_hold = 1'b0;
	logic phase_spacing_select = 1'b0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, crystal_input, reference_input, loop_return_input;
	logic outside_oscillator_input_p, outside_oscillator_input_n, bit_rate_transmit_clock_p;
	logic bit_rate_transmit_clock_n, serial_load_strobe_p, serial_load_strobe_n, symbol_rate_clock;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [NUM_PHASES-1:0] byte_clock_phases;
	logic [7:0] cap [0:39];
	int n_fail = 0, comparisons = 0, n;

	always #2 aclk = ~aclk;

	ring_network_clock_generator u_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(1'b1), .reference_select(reference_select), .crystal_input(crystal_input),
		.reference_input(reference_input), .oscillator_source_select(oscillator_source_select),
		.outside_oscillator_input_p(outside_oscillator_input_p),
		.outside_oscillator_input_n(outside_oscillator_input_n), .oscillator_hold(oscillator_hold),
		.phase_spacing_select(phase_spacing_select), .loop_return_input(loop_return_input),
		.bit_rate_transmit_clock_p(bit_rate_transmit_clock_p), .bit_rate_transmit_clock_n(bit_rate_transmit_clock_n),
		.serial_load_strobe_p(serial_load_strobe_p), .serial_load_strobe_n(serial_load_strobe_n),
		.byte_clock_phases(byte_clock_phases), .symbol_rate_clock(symbol_rate_clock));

	ring_clock_partner u_partner (
		.aclk(aclk), .outside_run(outside_run), .byte_clock_phases(byte_clock_phases),
		.crystal_input(crystal_input), .reference_input(reference_input),
		.outside_oscillator_input_p(outside_oscillator_input_p),
		.outside_oscillator_input_n(outside_oscillator_input_n), .loop_return_input(loop_return_input));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		comparisons++;
		if (seen !== expected)
		begin
			n_fail++;
			$display("[FAIL] %0t ns seen %h expected %h", $time, seen, expected);
		end
	endtask

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// bready and rready stay high, so every response is taken at the edge it is seen
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			aw_ok = aw_ok | awready;
			w_ok = w_ok | wready;
			if (aw_ok)
				awvalid <= 1'b0;
			if (w_ok)
				wvalid <= 1'b0;
		end
		while (!bvalid)
			@(posedge aclk);
		r = bresp;
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask

	// one byte period sampled from a byte phase one rise, against the phase tables
	task automatic check_wave(input int s);
		int r;
		logic [7:0] e;
		r = 0;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge aclk);
			cap[i] = {symbol_rate_clock, serial_load_strobe_p, bit_rate_transmit_clock_p, byte_clock_phases};
		end
		for (int i = 1; i < 21; i++)
			if (r == 0 && cap[i][0] && !cap[i-1][0])
				r = i;
		for (int j = 0; j < 20; j++)
		begin
			e[7] = (j % 10) >= 6;
			e[6] = ((j + 3) % 20) < 10;
			e[5] = (j % 2) == 0;
			for (int k = 0; k < 5; k++)
				e[k] = ((j - k * s + 40) % 20) < 10;
			check(32'(cap[r + j]), 32'(e));
		end
	endtask

	task automatic count_tx_edges(input int cycles, output int c);
		logic last;
		c = 0;
		last = bit_rate_transmit_clock_p;
		repeat (cycles)
		begin
			@(posedge aclk);
			if (bit_rate_transmit_clock_p !== last)
				c++;
			last = bit_rate_transmit_clock_p;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(CONTROL_OFFSET, rd, resp);
		check(rd, CONTROL_RESET);
		// low byte lane off: the loop enable must stay as it was
		wstrb <= 4'hE;
		axi_write(CONTROL_OFFSET, 32'h00000000, resp);
		wstrb <= 4'hF;
		axi_read(CONTROL_OFFSET, rd, resp);
		check(rd, CONTROL_RESET);
		axi_write(STATUS_OFFSET, 32'hFFFFFFFF, resp);
		check(32'(resp), 32'(RESP_OKAY));
		axi_read(12'h00C, rd, resp);
		check({rd[31:2], resp}, {30'h0, RESP_SLVERR});
		axi_write(12'h00C, 32'h00000001, resp);
		check(32'(resp), 32'(RESP_SLVERR));
		for (int m = 0; m < 16; m++)
		begin
			{oscillator_hold, phase_spacing_select, oscillator_source_select, reference_select} <= 4'(m);
			axi_read(STATUS_OFFSET, rd, resp);
			check(32'(rd[4:1]), 32'(m));
		end
		{oscillator_hold, phase_spacing_select, oscillator_source_select, reference_select} <= 4'h2;
		repeat (400) @(posedge aclk);
		axi_write(STEER_COUNT_OFFSET, 32'h00000000, resp);
		repeat (100) @(posedge aclk);
		axi_read(STATUS_OFFSET, rd, resp);
		check(32'(rd[0]), 32'h1);
		axi_read(STEER_COUNT_OFFSET, rd, resp);
		check(rd, 32'h00000000);
		check_wave(2);
		phase_spacing_select <= 1'b1;
		repeat (4) @(posedge aclk);
		check_wave(4);
		// external reference sits seven ticks off, so the loop must move to follow it
		axi_write(CONTROL_OFFSET, 32'h00000000, resp);
		reference_select <= 1'b1;
		axi_write(STEER_COUNT_OFFSET, 32'h00000000, resp);
		repeat (200) @(posedge aclk);
		axi_read(STEER_COUNT_OFFSET, rd, resp);
		check(rd, 32'h00000000);
		axi_read(STATUS_OFFSET, rd, resp);
		check(32'(rd[0]), 32'h0);
		axi_write(CONTROL_OFFSET, 32'h00000001, resp);
		repeat (600) @(posedge aclk);
		axi_read(STATUS_OFFSET, rd, resp);
		check(32'(rd[0]), 32'h1);
		axi_read(STEER_COUNT_OFFSET, rd, resp);
		check(32'(rd != 32'h0), 32'h1);
		oscillator_hold <= 1'b1;
		repeat (6) @(posedge aclk);
		count_tx_edges(20, n);
		check(32'(n), 32'h0);
		oscillator_hold <= 1'b0;
		axi_write(CONTROL_OFFSET, 32'h00000000, resp);
		oscillator_source_select <= 1'b0;
		outside_run <= 1'b1;
		repeat (6) @(posedge aclk);
		count_tx_edges(40, n);
		check(32'(n), 32'h14);
		outside_run <= 1'b0;
		repeat (6) @(posedge aclk);
		count_tx_edges(40, n);
		check(32'(n), 32'h0);
		conclude();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		$display("[FAIL] %0t ns watchdog expired", $time);
		conclude();
	end
endmodule
